// >>> rtl/plc_level_ctrl.sv
// Pulse-count brightness controller for a four-channel LED current driver.
//
// Behaviour
// - Rising edges on the control pin are counted into one of 32 levels 1 dB apart.
// - Code 32 selects full scale and code 1 selects full scale less 31 dB, rising monotonically.
// - The counter is modulo 32, so the edge after code 32 returns to code 1.
// - Each rising edge raises the level one step, and 31 edges lower it one step.
// - Edges up to 1 MHz are counted and each code passed in a burst reaches the output while the pin is high.
// - From shutdown the first rising edge enables the device at the lowest code.
// - The programmed level is held for as long as the pin stays high.
// - The outputs turn off and the device shuts down after the pin stays low for 500 us.
// - Edges keep being counted during soft start so one burst sets the final level.
// - Each code maps to a tabulated current from 0.549 mA to 20.000 mA.
// - The same level drives all four outputs, each at most 20 mA.
module plc_level_ctrl #(
	parameter int unsigned OFF_TIMEOUT_CYC = plc_pkg::PLC_OFF_TIMEOUT_CYC,
	parameter int unsigned SOFT_START_CYC = plc_pkg::PLC_SOFT_START_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Control pin, synchronous to clk
	input wire logic ctrl_pin,
	// Current source drive
	output logic [plc_pkg::PLC_LEVEL_W-1:0] level_code,
	output logic [plc_pkg::PLC_CUR_W-1:0] led_current,
	output logic [plc_pkg::PLC_CHANNELS-1:0] led_current_outputs,
	// Status
	output plc_pkg::plc_status_t status
);
	import plc_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	plc_state_t state, next_state;
	logic pin_d, next_pin_d;
	logic [4:0] count, next_count;
	logic [19:0] off_tmr, next_off_tmr;
	logic [19:0] ss_tmr, next_ss_tmr;
	logic [4:0] next_level_code;
	logic [14:0] next_led_current;
	logic [3:0] next_outputs;
	plc_status_t next_status;
	logic rise;
	logic fall;

	assign rise = ctrl_pin && !pin_d;
	assign fall = !ctrl_pin && pin_d;

	// Edge counting, off timer and output staging; outputs follow the
	// count only while the pin is high, so each code passed inside a burst of
	// short low pulses reaches the drive lines at its rising edge.
	always_comb begin
		next_state = state;
		next_pin_d = ctrl_pin;
		next_count = count;
		next_off_tmr = off_tmr;
		next_ss_tmr = ss_tmr;
		case (state)
			PLC_OFF: begin
				next_off_tmr = PLC_TMR_ZERO;
				if (rise) begin
					next_state = PLC_ON;
					next_count = PLC_LEVEL_MIN;
					next_ss_tmr = SOFT_START_CYC[19:0];
				end
			end
			PLC_ON: begin
				if (ss_tmr != PLC_TMR_ZERO) begin
					next_ss_tmr = ss_tmr - PLC_TMR_ONE;
				end
				// Rising edges are counted during soft start too.
				if (rise) begin
					next_count = count + PLC_LEVEL_STEP;
				end
				if (ctrl_pin) begin
					next_off_tmr = PLC_TMR_ZERO;
				end else if (fall) begin
					next_off_tmr = PLC_TMR_ONE;
				end else if (off_tmr >= OFF_TIMEOUT_CYC[19:0] - PLC_TMR_ONE) begin
					next_state = PLC_OFF;
					next_count = PLC_LEVEL_MIN;
					next_off_tmr = PLC_TMR_ZERO;
					next_ss_tmr = PLC_TMR_ZERO;
				end else begin
					next_off_tmr = off_tmr + PLC_TMR_ONE;
				end
			end
			default: begin
				next_state = PLC_OFF;
				next_count = PLC_LEVEL_MIN;
				next_off_tmr = PLC_TMR_ZERO;
				next_ss_tmr = PLC_TMR_ZERO;
			end
		endcase
		next_level_code = level_code;
		next_led_current = led_current;
		next_outputs = led_current_outputs;
		if (next_state != PLC_ON) begin
			next_level_code = PLC_LEVEL_MIN;
			next_led_current = '0;
			next_outputs = '0;
		end else if (ctrl_pin) begin
			next_level_code = next_count;
			next_led_current = plc_current_ua(next_count);
			next_outputs = '1;
		end
		next_status.enabled = (next_state == PLC_ON);
		next_status.soft_start = (next_ss_tmr != PLC_TMR_ZERO);
		next_status.level = next_level_code;
	end

	// Registers only.
	always_ff @(posedge clk) begin
		if (reset) begin
			state <= PLC_OFF;
			pin_d <= 1'b0;
			count <= PLC_LEVEL_MIN;
			off_tmr <= PLC_TMR_ZERO;
			ss_tmr <= PLC_TMR_ZERO;
			level_code <= PLC_LEVEL_MIN;
			led_current <= '0;
			led_current_outputs <= '0;
			status <= '0;
		end else begin
			state <= next_state;
			pin_d <= next_pin_d;
			count <= next_count;
			off_tmr <= next_off_tmr;
			ss_tmr <= next_ss_tmr;
			level_code <= next_level_code;
			led_current <= next_led_current;
			led_current_outputs <= next_outputs;
			status <= next_status;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_first_edge;
		state == PLC_OFF && ctrl_pin && !pin_d;
	endsequence

	// A counted edge below full scale, and one that sits at full scale.
	sequence s_rise_below_max;
		state == PLC_ON && ctrl_pin && !pin_d && count != PLC_LEVEL_MAX;
	endsequence

	sequence s_rise_at_max;
		state == PLC_ON && ctrl_pin && !pin_d && count == PLC_LEVEL_MAX;
	endsequence

	// The pin drops while the device is on.
	sequence s_fall_on;
		state == PLC_ON && !ctrl_pin && pin_d;
	endsequence

	chk_first_edge_min: assert property (@(posedge clk) disable iff (reset)
		s_first_edge |=> state == PLC_ON && level_code == PLC_LEVEL_MIN && led_current_outputs == 4'hF)
		else $error("first edge did not enable at lowest code");

	chk_edge_step: assert property (@(posedge clk) disable iff (reset)
		(state == PLC_ON && ctrl_pin && !pin_d) |=> count == $past(count) + PLC_LEVEL_STEP)
		else $error("rising edge did not step the level");

	chk_count_wrap: assert property (@(posedge clk) disable iff (reset)
		(state == PLC_ON && ctrl_pin && !pin_d && count == PLC_LEVEL_MAX) |=> count == PLC_LEVEL_MIN)
		else $error("level did not wrap to code 1");

	chk_high_hold: assert property (@(posedge clk) disable iff (reset)
		(state == PLC_ON && ctrl_pin && pin_d) ##1 (ctrl_pin && pin_d) |=>
		$stable(level_code) && led_current_outputs == 4'hF)
		else $error("level changed while pin held high");

	chk_low_hold: assert property (@(posedge clk) disable iff (reset)
		(state == PLC_ON && !ctrl_pin && next_state == PLC_ON) |=> $stable(level_code))
		else $error("output moved while pin low");

	chk_off_shut: assert property (@(posedge clk) disable iff (reset)
		(state == PLC_ON && !ctrl_pin && off_tmr == OFF_TIMEOUT_CYC[19:0] - PLC_TMR_ONE) |=>
		state == PLC_OFF && led_current_outputs == 4'h0)
		else $error("off timeout did not shut down");

	chk_tmr_clear: assert property (@(posedge clk) disable iff (reset)
		(state == PLC_ON && ctrl_pin) |=> off_tmr == PLC_TMR_ZERO)
		else $error("off timer not cleared by high pin");

	chk_table_map: assert property (@(posedge clk) disable iff (reset)
		status.enabled |-> led_current == plc_current_ua(level_code))
		else $error("current does not match level code");

	chk_ss_count: assert property (@(posedge clk) disable iff (reset)
		(ss_tmr != PLC_TMR_ZERO && state == PLC_ON && ctrl_pin && !pin_d) |=>
		count != $past(count))
		else $error("edge lost during soft start");

	// Shutdown leaves every drive line dark, whatever the pin did before.
	chk_shut_dark: assert property (@(posedge clk) disable iff (reset)
		state == PLC_OFF |-> led_current_outputs == 4'h0 && led_current == '0 && !status.enabled)
		else $error("outputs active in shutdown");

	// Every counted step below full scale must brighten the drive.
	chk_step_brighter: assert property (@(posedge clk) disable iff (reset)
		s_rise_below_max |=> led_current > $past(led_current))
		else $error("level step did not raise the current");

	// The edge after full scale drops the current to the floor of the table.
	chk_wrap_floor: assert property (@(posedge clk) disable iff (reset)
		s_rise_at_max |=> led_current == plc_current_ua(PLC_LEVEL_MIN))
		else $error("wrap did not return to the lowest current");

	// The level shown equals the count while on, so a held pin keeps the programmed level.
	chk_code_follow: assert property (@(posedge clk) disable iff (reset)
		state == PLC_ON |-> level_code == count && status.level == level_code)
		else $error("shown level differs from the count");

	// A falling edge restarts the off timer at one.
	chk_tmr_restart: assert property (@(posedge clk) disable iff (reset)
		s_fall_on |=> off_tmr == PLC_TMR_ONE)
		else $error("off timer not restarted by falling edge");

	// Soft start is only flagged while the device is enabled.
	chk_ss_enabled: assert property (@(posedge clk) disable iff (reset)
		status.soft_start |-> status.enabled)
		else $error("soft start flagged while disabled");

endmodule

// >>> rtl/plc_pkg.sv
// Package of constants and types for the pulse-count LED level controller.
package plc_pkg;

	// ----------------------------------------
	// Level code
	// ----------------------------------------
	localparam int unsigned PLC_LEVEL_W = 5;
	localparam logic [4:0] PLC_LEVEL_MIN = 5'h00; // Stored code 0 means level code 1.
	localparam logic [4:0] PLC_LEVEL_MAX = 5'h1F; // Stored code 31 means level code 32.
	localparam logic [4:0] PLC_LEVEL_STEP = 5'h01;
	localparam int unsigned PLC_CHANNELS = 4;
	localparam int unsigned PLC_CUR_W = 15;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned PLC_CLK_MHZ = 100;
	localparam int unsigned PLC_OFF_TIMEOUT_US = 500;
	localparam int unsigned PLC_OFF_TIMEOUT_CYC = PLC_OFF_TIMEOUT_US * PLC_CLK_MHZ;
	localparam int unsigned PLC_SOFT_START_US = 400;
	localparam int unsigned PLC_SOFT_START_CYC = PLC_SOFT_START_US * PLC_CLK_MHZ;
	localparam int unsigned PLC_TMR_W = 20;
	localparam logic [19:0] PLC_TMR_ZERO = 20'h00000;
	localparam logic [19:0] PLC_TMR_ONE = 20'h00001;

	// ----------------------------------------
	// States and carrier
	// ----------------------------------------
	typedef enum logic [1:0] {
		PLC_OFF = 2'h1,
		PLC_ON = 2'h2
	} plc_state_t;

	typedef struct packed {
		logic enabled;
		logic soft_start;
		logic [4:0] level;
	} plc_status_t;

	// Current per code in microamps, 1 dB per step.
	function automatic logic [14:0] plc_current_ua(input logic [4:0] code);
		logic [14:0] t;
		t = 15'h0000;
		case (code)
			5'h00: t = 15'd549; 5'h01: t = 15'd627; 5'h02: t = 15'd706; 5'h03: t = 15'd784;
			5'h04: t = 15'd863; 5'h05: t = 15'd1020; 5'h06: t = 15'd1098; 5'h07: t = 15'd1255;
			5'h08: t = 15'd1412; 5'h09: t = 15'd1569; 5'h0A: t = 15'd1804; 5'h0B: t = 15'd1961;
			5'h0C: t = 15'd2275; 5'h0D: t = 15'd2510; 5'h0E: t = 15'd2824; 5'h0F: t = 15'd3137;
			5'h10: t = 15'd3529; 5'h11: t = 15'd4000; 5'h12: t = 15'd4471; 5'h13: t = 15'd5020;
			5'h14: t = 15'd5647; 5'h15: t = 15'd6353; 5'h16: t = 15'd7059; 5'h17: t = 15'd7922;
			5'h18: t = 15'd8941; 5'h19: t = 15'd10039; 5'h1A: t = 15'd11216; 5'h1B: t = 15'd12627;
			5'h1C: t = 15'd14118; 5'h1D: t = 15'd15843; 5'h1E: t = 15'd17804;
			default: t = 15'd20000;
		endcase
		return t;
	endfunction

endpackage

// >>> test/plc_host_model.sv
// Host-side driver model that toggles the control pin of the level controller.
module plc_host_model (
	// Clock
	input wire logic clk,
	// Control pin towards the device
	output logic ctrl_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	// The pin starts low so the device sees shutdown until the first rising edge.
	initial begin
		ctrl_pin = 1'b0;
	end

	// Hold the pin at one level for c sampled edges. It changes on a rising edge by
	// non-blocking assignment, and the task returns at a falling edge, so the bench
	// reads settled outputs rather than racing the edge that launches them.
	task automatic drive(input logic v, input int c);
		@(posedge clk);
		ctrl_pin <= v;
		repeat (c - 1) @(posedge clk);
		@(negedge clk);
	endtask

	// Send edges and leave the pin high between and after them.
	// Low phases stay short of the off timeout unless the bench asks otherwise.
	task automatic send(input int n, input int lo, input int hi);
		repeat (n) begin
			drive(1'b0, lo);
			drive(1'b1, hi);
		end
	endtask
endmodule

// >>> test/plc_level_ctrl_tb.sv
// Self-checking bench for the pulse-count LED level controller.
module plc_level_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import plc_pkg::*;
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin errors++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, s); end end

	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	localparam int unsigned OFF_CYC = 20;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ctrl_pin;
	logic [4:0] level_code;
	logic [14:0] led_current;
	logic [3:0] led_current_outputs;
	plc_status_t status;
	int errors = 0;
	int check_count = 0;
	logic [31:0] lfsr = 32'hAA02;
	logic [14:0] prev_ua;
	int n;

	// The clock toggles every half period of 5 ns.
	always #5 clk = ~clk;

	plc_host_model host (.clk(clk), .ctrl_pin(ctrl_pin));
	plc_level_ctrl #(.OFF_TIMEOUT_CYC(OFF_CYC), .SOFT_START_CYC(10)) dut (.clk(clk),
		.reset(reset), .ctrl_pin(ctrl_pin), .level_code(level_code),
		.led_current(led_current), .led_current_outputs(led_current_outputs), .status(status));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Shift register source of repeatable random values.
	function automatic int next_rand();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return int'(lfsr[15:0]);
	endfunction

	// Stored code expected after a burst of k edges from shutdown, wrapping modulo 32.
	function automatic logic [4:0] burst_code(input int k);
		return 5'((k - 1) % 32);
	endfunction

	// Check that the device is on at the given stored code, on all four outputs.
	task automatic expect_on(input logic [4:0] l);
		`CHK("level_code", l, level_code)
		`CHK("status.level", l, status.level)
		`CHK("status.enabled", 1'b1, status.enabled)
		`CHK("led_current_outputs", 4'hF, led_current_outputs)
	endtask

	// Print the counts and the verdict, then stop.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// A hang is cut short well inside the cycle budget.
	initial begin
		repeat (90000) @(posedge clk);
		errors++;
		complete_run();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		`CHK("off outputs", 4'h0, led_current_outputs)
		host.send(1, 2, 3);
		expect_on(5'h00);
		`CHK("led_current", 15'd549, led_current)
		`CHK("soft_start", 1'b1, status.soft_start)
		$display("test first_edge done");
		// Single steps up to full scale, each one brighter than the last.
		prev_ua = led_current;
		for (int i = 1; i < 32; i++) begin
			host.send(1, 1, 2);
			expect_on(5'(i));
			`CHK("monotonic", 1'b1, led_current > prev_ua)
			prev_ua = led_current;
			if (i == 17) `CHK("led_current", 15'd4000, led_current)
		end
		`CHK("full scale", 15'd20000, led_current)
		host.send(1, 1, 2);
		expect_on(5'h00);
		host.send(31, 1, 1);
		host.drive(1'b1, 2);
		expect_on(5'h1F);
		`CHK("soft_start end", 1'b0, status.soft_start)
		$display("test steps done");
		// Long high hold, then a low just short of the timeout.
		host.drive(1'b1, 60);
		expect_on(5'h1F);
		host.send(1, OFF_CYC - 1, 2);
		expect_on(5'h00);
		host.drive(1'b0, OFF_CYC + 3);
		`CHK("shutdown outputs", 4'h0, led_current_outputs)
		`CHK("shutdown current", 15'h0000, led_current)
		`CHK("shutdown enabled", 1'b0, status.enabled)
		$display("test timeout done");
		// Random bursts with low phases of one to three cycles and one-cycle highs, each from shutdown.
		for (int r = 0; r < 8; r++) begin
			n = 1 + next_rand() % 40;
			host.send(n, 1 + next_rand() % 3, 1);
			host.drive(1'b1, 2);
			expect_on(burst_code(n));
			host.drive(1'b0, OFF_CYC + 3);
			`CHK("burst off", 1'b0, status.enabled)
		end
		$display("test bursts done");
		complete_run();
	end
endmodule
